// >>> rtl/rss_pkg.sv
// Constants and carrier types for the rotate/set/sleep execution block
package rss_pkg;

   // Opcode fields: rotate is word bits 15:10, set-ones bits 15:9, sleep the whole word
   localparam logic [5:0] RSS_OP_ROTATE     = 6'h10;
   localparam logic [6:0] RSS_OP_SETONES    = 7'h34;
   localparam logic [15:0] RSS_OP_SLEEP     = 16'h0003;
   localparam int         RSS_D_BIT         = 9;
   localparam int         RSS_A_BIT         = 8;

   // Operand and addressing
   localparam logic [7:0] RSS_ALL_ONES      = 8'hFF;
   localparam logic [7:0] RSS_INDEX_LIMIT   = 8'h5F;
   localparam logic [7:0] RSS_ACCESS_SPLIT  = 8'h60;
   localparam logic [3:0] RSS_ACCESS_HI_BANK = 4'hF;
   localparam logic [3:0] RSS_ACCESS_LO_BANK = 4'h0;

   // Status bit positions
   localparam int         RSS_FLAG_N        = 4;
   localparam int         RSS_FLAG_Z        = 2;

   // Interrupt status bits
   localparam int         RSS_EV_SLEEP      = 0;
   localparam int         RSS_EV_WDT_WAKE   = 1;
   localparam int         RSS_EV_DONE       = 2;
   localparam logic [2:0] RSS_EV_RESET      = 3'h0;
   localparam logic [2:0] RSS_MASK_RESET    = 3'h0;

   // Register port offsets
   localparam logic [1:0] RSS_REG_STATUS    = 2'h0;
   localparam logic [1:0] RSS_REG_MASK      = 2'h1;
   localparam logic [1:0] RSS_REG_CTRL      = 2'h2;
   localparam logic [1:0] RSS_REG_STATE     = 2'h3;

   localparam logic [7:0] RSS_STATUS_RESET  = 8'h00;
   localparam logic [7:0] RSS_ACC_RESET     = 8'h00;

   typedef enum logic [1:0] {
      RSS_Q1,
      RSS_Q2,
      RSS_Q3,
      RSS_Q4
   } rss_phase_type;

   // Data memory write request
   typedef struct packed {
      logic        we;
      logic [11:0] addr;
      logic [7:0]  data;
   } rss_mem_wr_type;

endpackage : rss_pkg

// >>> rtl/rss_addr_gen.sv
// Data memory address generation for byte-oriented operands
`timescale 1ns/1ps
module rss_addr_gen
   import rss_pkg::*;
(
   input  wire logic [7:0]  f_field,
   input  wire logic        a_bit,
   input  wire logic        ext_set_en,
   input  wire logic [3:0]  bank_select_register,
   input  wire logic [11:0] index_base,
   output logic      [11:0] addr,
   output logic             indexed
);
   always_comb begin
      indexed = 1'b0;
      if (a_bit) begin
         addr = {bank_select_register, f_field};
      end else if (ext_set_en && f_field <= RSS_INDEX_LIMIT) begin
         indexed = 1'b1;
         addr    = index_base + {4'h0, f_field};
      end else if (f_field >= RSS_ACCESS_SPLIT) begin
         addr = {RSS_ACCESS_HI_BANK, f_field};
      end else begin
         addr = {RSS_ACCESS_LO_BANK, f_field};
      end
   end
endmodule : rss_addr_gen

// >>> rtl/rss_exec.sv
// Four-phase executor for rotate-right, set-all-ones and sleep instructions
`timescale 1ns/1ps
module rss_exec
   import rss_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   input  wire logic        ext_set_en,
   input  wire logic [3:0]  bank_select_register,
   input  wire logic [11:0] index_base,
   input  wire logic [7:0]  mem_rd_data,
   input  wire logic        wdt_wake,
   input  wire logic        other_wake,
   input  wire logic [1:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   output logic      [11:0] mem_rd_addr,
   output rss_mem_wr_type   mem_wr,
   output logic      [7:0]  acc_q,
   output logic      [7:0]  status_q,
   output logic             power_down_flag_q,
   output logic             watchdog_expiry_flag_q,
   output logic             wdt_clear_q,
   output logic             osc_halt_q,
   output logic             busy_q,
   output logic             irq_q
);
   rss_phase_type  phase_q;
   logic [15:0]    ir_q;
   logic [7:0]     opnd_q;
   logic [7:0]     res_q;
   logic [11:0]    ea;
   logic           ea_indexed;
   logic           is_rot;
   logic           is_set;
   logic           is_slp;
   logic [2:0]     ev_q;
   logic [2:0]     mask_q;
   logic [2:0]     ev_set;
   logic           ext_ctrl_q;
   logic           idx_seen_q;

   assign is_rot = (ir_q[15:10] == RSS_OP_ROTATE);
   assign is_set = (ir_q[15:9] == RSS_OP_SETONES);
   assign is_slp = (ir_q == RSS_OP_SLEEP);

   rss_addr_gen u_addr (
      .f_field              (ir_q[7:0]),
      .a_bit                (ir_q[RSS_A_BIT]),
      .ext_set_en           (ext_set_en | ext_ctrl_q),
      .bank_select_register (bank_select_register),
      .index_base           (index_base),
      .addr                 (ea),
      .indexed              (ea_indexed)
   );

   // Phase sequencer; idle in Q1 until an instruction is offered
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_q <= RSS_Q1;
         busy_q  <= 1'b0;
         ir_q    <= 16'h0000;
      end else if (clk_en && !osc_halt_q) begin
         case (phase_q)
            RSS_Q1: begin
               if (instr_valid) begin
                  ir_q    <= instr_word;
                  busy_q  <= 1'b1;
                  phase_q <= RSS_Q2;
               end
            end
            RSS_Q2: phase_q <= RSS_Q3;
            RSS_Q3: phase_q <= RSS_Q4;
            RSS_Q4: begin
               busy_q  <= 1'b0;
               phase_q <= RSS_Q1;
            end
            default: phase_q <= RSS_Q1;
         endcase
      end
   end

   // Operand read in Q2
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_rd_addr <= 12'h000;
         opnd_q      <= 8'h00;
         idx_seen_q  <= 1'b0;
      end else if (clk_en && !osc_halt_q) begin
         mem_rd_addr <= ea;
         if (phase_q == RSS_Q2) begin
            opnd_q     <= mem_rd_data;
            idx_seen_q <= ea_indexed;
         end
      end
   end

   // Processing in Q3
   always_ff @(posedge clock) begin
      if (rst) begin
         res_q <= 8'h00;
      end else if (clk_en && !osc_halt_q && phase_q == RSS_Q3) begin
         if (is_set) begin
            res_q <= RSS_ALL_ONES;
         end else begin
            res_q <= {opnd_q[0], opnd_q[7:1]};
         end
      end
   end

   // Destination write in Q4
   always_ff @(posedge clock) begin
      if (rst) begin
         mem_wr   <= '0;
         acc_q    <= RSS_ACC_RESET;
         status_q <= RSS_STATUS_RESET;
      end else if (clk_en) begin
         mem_wr.we <= 1'b0;
         if (!osc_halt_q && phase_q == RSS_Q4) begin
            if (is_rot) begin
               if (ir_q[RSS_D_BIT]) begin
                  mem_wr.we   <= 1'b1;
                  mem_wr.addr <= ea;
                  mem_wr.data <= res_q;
               end else begin
                  acc_q <= res_q;
               end
               status_q[RSS_FLAG_N] <= res_q[7];
               status_q[RSS_FLAG_Z] <= (res_q == 8'h00);
            end else if (is_set) begin
               mem_wr.we   <= 1'b1;
               mem_wr.addr <= ea;
               mem_wr.data <= res_q;
            end
         end
      end
   end

   // Power flags, watchdog clear and oscillator halt
   always_ff @(posedge clock) begin
      if (rst) begin
         power_down_flag_q      <= 1'b1;
         watchdog_expiry_flag_q <= 1'b1;
         wdt_clear_q            <= 1'b0;
         osc_halt_q             <= 1'b0;
      end else if (clk_en) begin
         wdt_clear_q <= 1'b0;
         if (!osc_halt_q && phase_q == RSS_Q4 && is_slp) begin
            power_down_flag_q      <= 1'b0;
            watchdog_expiry_flag_q <= 1'b1;
            wdt_clear_q            <= 1'b1;
            osc_halt_q             <= 1'b1;
         end else if (osc_halt_q && wdt_wake) begin
            watchdog_expiry_flag_q <= 1'b0;
            osc_halt_q             <= 1'b0;
         end else if (osc_halt_q && other_wake) begin
            osc_halt_q <= 1'b0;
         end
      end
   end

   // Interrupt events: set beats write-one-to-clear
   always_comb begin
      ev_set                  = 3'h0;
      ev_set[RSS_EV_SLEEP]    = !osc_halt_q && phase_q == RSS_Q4 && is_slp;
      ev_set[RSS_EV_WDT_WAKE] = osc_halt_q && wdt_wake;
      ev_set[RSS_EV_DONE]     = !osc_halt_q && phase_q == RSS_Q4;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ev_q <= RSS_EV_RESET;
      end else if (clk_en) begin
         ev_q <= (ev_q & ~((reg_wr && reg_addr == RSS_REG_STATUS) ? reg_wdata[2:0] : 3'h0))
                 | ev_set;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mask_q     <= RSS_MASK_RESET;
         ext_ctrl_q <= 1'b0;
      end else if (clk_en && reg_wr) begin
         if (reg_addr == RSS_REG_MASK) begin
            mask_q <= reg_wdata[2:0];
         end else if (reg_addr == RSS_REG_CTRL) begin
            ext_ctrl_q <= reg_wdata[0];
         end
      end
   end

   // Registered so irq lags status by one cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else if (clk_en) begin
         irq_q <= |(ev_q & mask_q);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            if (reg_addr == RSS_REG_STATUS) begin
               reg_rdata <= {5'h00, ev_q};
            end else if (reg_addr == RSS_REG_MASK) begin
               reg_rdata <= {5'h00, mask_q};
            end else if (reg_addr == RSS_REG_CTRL) begin
               reg_rdata <= {7'h00, ext_ctrl_q};
            end else begin
               reg_rdata <= {idx_seen_q, osc_halt_q, power_down_flag_q,
                             watchdog_expiry_flag_q, busy_q, 1'b0, phase_q};
            end
         end
      end
   end

   // Assertions
   sequence s_sleep_q4;
      !osc_halt_q && phase_q == RSS_Q4 && is_slp && clk_en;
   endsequence

   property p_rot_result;
      @(posedge clock) disable iff (rst)
      (clk_en && !osc_halt_q && phase_q == RSS_Q3 && is_rot)
         |=> (res_q == {$past(opnd_q[0]), $past(opnd_q[7:1])});
   endproperty
   a_rot_result: assert property (p_rot_result) else $error("rotate result wrong");

   property p_rot_dest;
      @(posedge clock) disable iff (rst)
      (clk_en && !osc_halt_q && phase_q == RSS_Q4 && is_rot && !ir_q[RSS_D_BIT])
         |=> (acc_q == $past(res_q)) && !mem_wr.we;
   endproperty
   a_rot_dest: assert property (p_rot_dest) else $error("rotate to acc wrong");

   property p_bank;
      @(posedge clock) disable iff (rst)
      ir_q[RSS_A_BIT] |-> ea == {bank_select_register, ir_q[7:0]};
   endproperty
   a_bank: assert property (p_bank) else $error("bank address wrong");

   property p_index;
      @(posedge clock) disable iff (rst)
      (!ir_q[RSS_A_BIT] && ext_set_en && ir_q[7:0] <= RSS_INDEX_LIMIT) |-> ea_indexed;
   endproperty
   a_index: assert property (p_index) else $error("indexed mode missed");

   property p_set;
      @(posedge clock) disable iff (rst)
      (clk_en && !osc_halt_q && phase_q == RSS_Q4 && is_set)
         |=> mem_wr.we && mem_wr.data == RSS_ALL_ONES && $stable(status_q);
   endproperty
   a_set: assert property (p_set) else $error("set-ones wrong");

   property p_sleep;
      @(posedge clock) disable iff (rst)
      s_sleep_q4 |=> !power_down_flag_q && watchdog_expiry_flag_q && wdt_clear_q && osc_halt_q;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep effects wrong");

   property p_wake;
      @(posedge clock) disable iff (rst)
      (clk_en && osc_halt_q && wdt_wake) |=> !watchdog_expiry_flag_q && !osc_halt_q;
   endproperty
   a_wake: assert property (p_wake) else $error("watchdog wake flag wrong");

   property p_four_phase;
      @(posedge clock) disable iff (rst)
      (clk_en && !osc_halt_q && phase_q == RSS_Q1 && instr_valid) ##1 clk_en [*3]
         |=> phase_q == RSS_Q1;
   endproperty
   a_four_phase: assert property (p_four_phase) else $error("cycle not four phases");

   property p_clr_pulse;
      @(posedge clock) disable iff (rst)
      (wdt_clear_q && clk_en) |=> !wdt_clear_q;
   endproperty
   a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse wrong");

   // Halted core must neither advance nor write
   property p_halt;
      @(posedge clock) disable iff (rst)
      osc_halt_q |=> $stable(phase_q) && !mem_wr.we;
   endproperty
   a_halt: assert property (p_halt) else $error("activity while halted");

   property p_freeze;
      @(posedge clock) disable iff (rst)
      !clk_en |=> $stable(phase_q) && $stable(acc_q) && $stable(ev_q) && $stable(mem_wr);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

endmodule : rss_exec

// >>> tb/tb_rss_exec.sv
// Self-checking bench for the rotate/set/sleep executor
`timescale 1ns/1ps
module tb_rss_exec;
   import rss_pkg::*;

   logic           clock;
   logic           rst;
   logic           clk_en;
   logic           instr_valid;
   logic [15:0]    instr_word;
   logic           ext_set_en;
   logic [3:0]     bank_select_register;
   logic [11:0]    index_base;
   logic [7:0]     mem_rd_data;
   logic           wdt_wake;
   logic           other_wake;
   logic [1:0]     reg_addr;
   logic [7:0]     reg_wdata;
   logic           reg_wr;
   logic           reg_rd;
   logic [7:0]     reg_rdata;
   logic [11:0]    mem_rd_addr;
   rss_mem_wr_type mem_wr;
   logic [7:0]     acc_q;
   logic [7:0]     status_q;
   logic           power_down_flag_q;
   logic           watchdog_expiry_flag_q;
   logic           wdt_clear_q;
   logic           osc_halt_q;
   logic           busy_q;
   logic           irq_q;
   int             mismatches;
   int             tests_run;
   int             cycles = 0;
   int             hold_cycles;
   logic           ctrl_ext;
   logic [31:0]    seed;
   logic [7:0]     exp_acc;
   logic [7:0]     exp_status;
   logic [7:0]     rd;

   rss_exec dut (.clock(clock), .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid),
      .instr_word(instr_word), .ext_set_en(ext_set_en),
      .bank_select_register(bank_select_register), .index_base(index_base),
      .mem_rd_data(mem_rd_data), .wdt_wake(wdt_wake), .other_wake(other_wake),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .mem_rd_addr(mem_rd_addr), .mem_wr(mem_wr), .acc_q(acc_q),
      .status_q(status_q), .power_down_flag_q(power_down_flag_q),
      .watchdog_expiry_flag_q(watchdog_expiry_flag_q), .wdt_clear_q(wdt_clear_q),
      .osc_halt_q(osc_halt_q), .busy_q(busy_q), .irq_q(irq_q));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic results();
      if (mismatches == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   // Hang guard, well above the few hundred cycles the sequence needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         results();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [11:0] exp_addr(input logic [7:0] f, input logic a,
                                            input logic ext, input logic [3:0] b);
      if (a)
         return {b, f};
      if (ext && f <= 8'h5F)
         return index_base + {4'h0, f};
      return (f >= 8'h60) ? {4'hF, f} : {4'h0, f};
   endfunction : exp_addr

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
      end
   endtask : chk_byte

   task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t address got %h exp %h", $time, got, exp);
      end
   endtask : chk_addr

   task automatic chk_flag(input logic got, input logic exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
      end
   endtask : chk_flag

   // Offer in idle Q1, optional enable gap, sample one step after the Q4 edge
   task automatic run_instr(input logic [15:0] w);
      @(posedge clock);
      instr_valid <= 1'b1;
      instr_word  <= w;
      @(posedge clock);
      instr_valid <= 1'b0;
      if (hold_cycles > 0) begin
         clk_en <= 1'b0;
         #1;
         chk_flag(busy_q, 1'b1);
         repeat (hold_cycles) @(posedge clock);
         clk_en <= 1'b1;
      end
      repeat (3) @(posedge clock);
      #1;
   endtask : run_instr

   task automatic reg_access(input logic wr, input logic [1:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr    <= wr;
      reg_rd    <= ~wr;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      rd = reg_rdata;
   endtask : reg_access

   task automatic do_byte(input logic set, input logic d, input logic a, input logic [7:0] f,
                          input logic [7:0] v, input logic ext, input logic [3:0] b);
      logic [7:0] r;
      r = set ? RSS_ALL_ONES : {v[0], v[7:1]};
      @(posedge clock);
      ext_set_en           <= ext;
      bank_select_register <= b;
      mem_rd_data          <= v;
      run_instr(set ? {RSS_OP_SETONES, a, f} : {RSS_OP_ROTATE, d, a, f});
      if (!set) begin
         exp_status[RSS_FLAG_N] = r[7];
         exp_status[RSS_FLAG_Z] = (r == 8'h00);
      end
      if (!set && !d)
         exp_acc = r;
      chk_flag(mem_wr.we, set | d);
      if (set | d) begin
         chk_byte(mem_wr.data, r);
         chk_addr(mem_wr.addr, exp_addr(f, a, ext | ctrl_ext, b));
      end
      chk_addr(mem_rd_addr, exp_addr(f, a, ext | ctrl_ext, b));
      chk_byte(acc_q, exp_acc);
      chk_byte(status_q, exp_status);
   endtask : do_byte

   task automatic sleep_wake(input logic by_wdt);
      run_instr(RSS_OP_SLEEP);
      chk_flag(power_down_flag_q, 1'b0);
      chk_flag(watchdog_expiry_flag_q, 1'b1);
      chk_flag(wdt_clear_q, 1'b1);
      chk_flag(osc_halt_q, 1'b1);
      @(posedge clock);
      #1;
      chk_flag(wdt_clear_q, 1'b0);
      // Offered while halted, so nothing may be written
      run_instr({RSS_OP_SETONES, 1'b1, 8'h10});
      chk_flag(mem_wr.we, 1'b0);
      @(posedge clock);
      wdt_wake   <= by_wdt;
      other_wake <= ~by_wdt;
      for (int i = 0; i < 20 && osc_halt_q !== 1'b0; i++)
         @(posedge clock);
      wdt_wake   <= 1'b0;
      other_wake <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk_flag(osc_halt_q, 1'b0);
      chk_flag(watchdog_expiry_flag_q, ~by_wdt);
   endtask : sleep_wake

   initial begin
      logic [31:0] x;
      logic [7:0]  corner [4];
      corner = '{8'h5F, 8'h60, 8'h00, 8'hFF};
      mismatches = 0;
      tests_run = 0;
      hold_cycles = 0;
      ctrl_ext = 1'b0;
      seed = 32'hcf30;
      rst = 1'b1;
      clk_en = 1'b1;
      instr_valid = 1'b0;
      instr_word = 16'h0000;
      ext_set_en = 1'b0;
      bank_select_register = 4'h0;
      index_base = 12'h3A0;
      mem_rd_data = 8'h00;
      wdt_wake = 1'b0;
      other_wake = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      exp_acc = RSS_ACC_RESET;
      exp_status = RSS_STATUS_RESET;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      #1;
      chk_flag(power_down_flag_q, 1'b1);
      chk_flag(watchdog_expiry_flag_q, 1'b1);
      chk_byte(acc_q, RSS_ACC_RESET);
      // Index boundary and access bank split, both with extended set on
      for (int i = 0; i < 4; i++)
         do_byte(i[0], 1'b1, 1'b0, corner[i], 8'hD7, 1'b1, 4'h5);
      do_byte(1'b0, 1'b0, 1'b0, 8'h20, 8'hD7, 1'b0, 4'h2);
      do_byte(1'b0, 1'b0, 1'b0, 8'h20, 8'h00, 1'b0, 4'h2);
      for (int i = 0; i < 40; i++) begin
         x = rnd();
         // Random clock-enable gaps right after the take
         hold_cycles = int'(x[25:24]);
         do_byte(x[0], x[1], x[2], x[15:8], x[23:16], x[3], x[7:4]);
      end
      hold_cycles = 0;
      sleep_wake(1'b1);
      sleep_wake(1'b0);
      // Extended set turned on from the control register, pin low
      reg_access(1'b1, RSS_REG_CTRL, 8'h01);
      ctrl_ext = 1'b1;
      reg_access(1'b0, RSS_REG_CTRL, 8'h00);
      chk_byte(rd, 8'h01);
      do_byte(1'b0, 1'b1, 1'b0, 8'h30, 8'h81, 1'b0, 4'h7);
      reg_access(1'b0, RSS_REG_STATE, 8'h00);
      chk_byte(rd, 8'h90);
      reg_access(1'b1, RSS_REG_CTRL, 8'h00);
      ctrl_ext = 1'b0;
      reg_access(1'b0, RSS_REG_STATUS, 8'h00);
      chk_byte(rd & 8'h03, 8'h03);
      reg_access(1'b0, RSS_REG_MASK, 8'h00);
      chk_byte(rd, {5'h00, RSS_MASK_RESET});
      chk_flag(irq_q, 1'b0);
      reg_access(1'b1, RSS_REG_MASK, 8'h02);
      repeat (2) @(posedge clock);
      #1;
      chk_flag(irq_q, 1'b1);
      reg_access(1'b1, RSS_REG_STATUS, 8'h02);
      repeat (2) @(posedge clock);
      #1;
      chk_flag(irq_q, 1'b0);
      reg_access(1'b0, RSS_REG_STATUS, 8'h00);
      chk_flag(rd[RSS_EV_WDT_WAKE], 1'b0);
      results();
   end
endmodule : tb_rss_exec
